/* File: rtl/kswd_watchdog.sv */
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module kswd_watchdog (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [kswd_pkg::WB_ADR_W-1:0] wb_adr_i,
   input  wire logic [kswd_pkg::WB_SEL_W-1:0] wb_sel_i,
   input  wire logic [kswd_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic      [kswd_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          time_base_tap_256hz_i,
   output logic                               irq_o,
   output logic                               wd_overflow_irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus request
   kswd_pkg::kswd_wb_req_t req;
   logic                   req_new;
   logic                   wr_new;
   logic                   key_wr;
   logic [3:0]             key_val;

   assign req.cyc = wb_cyc_i;
   assign req.stb = wb_stb_i;
   assign req.we  = wb_we_i;
   assign req.adr = wb_adr_i;
   assign req.sel = wb_sel_i;
   assign req.dat = wb_dat_i;

   // Write is taken once, at the edge where ack rises
   assign req_new = req.cyc && req.stb && !wb_ack_o;
   assign wr_new  = req_new && req.we && req.sel[0];
   assign key_wr  = wr_new && (req.adr == kswd_pkg::KEY_ADR);
   assign key_val = req.dat[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // Time base tap: asynchronous to clk_i
   logic [1:0] tb_sync_q;
   logic       tb_prev_q;
   logic       tick;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tb_sync_q <= 2'h0;
         tb_prev_q <= 1'b0;
      end else begin
         tb_sync_q <= {tb_sync_q[0], time_base_tap_256hz_i};
         tb_prev_q <= tb_sync_q[1];
      end
   end

   assign tick = tb_sync_q[1] && !tb_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Key sequencer
   kswd_pkg::kswd_state_t         st_q;
   logic                          running_q;
   logic                          pointer_q;
   logic                          armed_q;
   logic [kswd_pkg::WD_CNT_W-1:0] count_q;
   logic                          key_done;
   logic                          ovf_now;
   logic                          bad_key;

   // One register per field keeps a single driver for every bit
   assign st_q = {running_q, pointer_q, armed_q, count_q};

   assign key_done = key_wr && st_q.pointer && st_q.armed
                     && (key_val == kswd_pkg::KEY_SECOND);
   // Anything but an accepted first key or a completing second key
   assign bad_key  = key_wr && !key_done
                     && (st_q.pointer || (key_val != kswd_pkg::KEY_FIRST));
   assign ovf_now  = tick && st_q.running && !key_done
                     && (st_q.count == kswd_pkg::WD_CNT_MAX);

   always_ff @(posedge clk_i) begin
      if (rst_i || ovf_now) begin
         pointer_q <= 1'b0;
         armed_q   <= 1'b0;
      end else if (key_wr) begin
         pointer_q <= !st_q.pointer;
         // Only 5H at pointer 0 arms; any other write disarms
         armed_q   <= !st_q.pointer
                      && (key_val == kswd_pkg::KEY_FIRST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         running_q <= 1'b0;
         count_q   <= kswd_pkg::WD_CNT_ZERO;
      end else if (key_done) begin
         // Clear is not aligned to the tick, so next tick may come early
         running_q <= 1'b1;
         count_q   <= kswd_pkg::WD_CNT_ZERO;
      end else if (tick && st_q.running) begin
         count_q   <= st_q.count + kswd_pkg::WD_CNT_ONE;
      end
   end

   // No mask and no disable on this line by design
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_overflow_irq_o <= 1'b0;
      end else begin
         wd_overflow_irq_o <= ovf_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status, mask and summary interrupt
   logic [kswd_pkg::EV_W-1:0] status_q;
   logic [kswd_pkg::EV_W-1:0] mask_q;
   logic [kswd_pkg::EV_W-1:0] events;
   logic [kswd_pkg::EV_W-1:0] w1c;

   always_comb begin
      events                      = kswd_pkg::EV_NONE;
      events[kswd_pkg::EV_OVF]    = ovf_now;
      events[kswd_pkg::EV_START]  = key_done && !st_q.running;
      events[kswd_pkg::EV_CLEAR]  = key_done && st_q.running;
      events[kswd_pkg::EV_BADKEY] = bad_key;
   end

   assign w1c = (wr_new && (req.adr == kswd_pkg::STAT_ADR))
                ? req.dat[kswd_pkg::EV_W-1:0] : kswd_pkg::EV_NONE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= kswd_pkg::EV_NONE;
      end else begin
         // A new event wins over a clear in the same cycle
         status_q <= (status_q & ~w1c) | events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= kswd_pkg::EV_NONE;
      end else if (wr_new && (req.adr == kswd_pkg::MASK_ADR)) begin
         mask_q <= req.dat[kswd_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer: ack one cycle after the request, unmapped reads zero
   logic [kswd_pkg::WB_DAT_W-1:0] rd_d;

   always_comb begin
      rd_d = kswd_pkg::DAT_ZERO;
      unique case (req.adr)
         kswd_pkg::STAT_ADR:  rd_d[kswd_pkg::EV_W-1:0] = status_q;
         kswd_pkg::MASK_ADR:  rd_d[kswd_pkg::EV_W-1:0] = mask_q;
         kswd_pkg::STATE_ADR: rd_d[$bits(st_q)-1:0]    = st_q;
         // Key register holds nothing readable
         kswd_pkg::KEY_ADR:   rd_d = kswd_pkg::DAT_ZERO;
         default:             rd_d = kswd_pkg::DAT_ZERO;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= kswd_pkg::DAT_ZERO;
      end else begin
         wb_ack_o <= req_new;
         wb_dat_o <= (req_new && !req.we) ? rd_d : kswd_pkg::DAT_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [9:0] ticks_since_q;

   // Ticks seen since the last start, clear or wrap; the counter runs on after a wrap
   always_ff @(posedge clk_i) begin
      if (rst_i || key_done || ovf_now) begin
         ticks_since_q <= kswd_pkg::WD_TICK_ZERO;
      end else if (tick && st_q.running) begin
         ticks_since_q <= ticks_since_q + kswd_pkg::WD_TICK_ONE;
      end
   end

   count_adv_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (tick && st_q.running && !key_done)
      |=> (st_q.count == $past(st_q.count) + kswd_pkg::WD_CNT_ONE))
      else $error("Counter did not advance on tick");

   reset_stop_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (!st_q.running && st_q.count == kswd_pkg::WD_CNT_ZERO
                        && !st_q.pointer && !wd_overflow_irq_o))
      else $error("Counter not stopped after reset");

   idle_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!st_q.running && !key_done) |=> (!st_q.running
                                        && st_q.count == kswd_pkg::WD_CNT_ZERO))
      else $error("Counter ran before start");

   start_seq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_wr && !st_q.pointer && key_val == kswd_pkg::KEY_FIRST && !ovf_now)
      |=> (st_q.armed && st_q.pointer))
      else $error("First key at pointer zero not armed");

   start_run_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_wr && st_q.armed && key_val == kswd_pkg::KEY_SECOND && !st_q.running)
      |=> (st_q.running && st_q.count == kswd_pkg::WD_CNT_ZERO
           && status_q[kswd_pkg::EV_START]))
      else $error("Start sequence did not start counter");

   ptr_toggle_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_wr && !ovf_now) |=> (st_q.pointer != $past(st_q.pointer)))
      else $error("Pointer did not toggle on key write");

   clear_seq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (st_q.running && key_done)
      |=> (st_q.count == kswd_pkg::WD_CNT_ZERO && st_q.running
           && status_q[kswd_pkg::EV_CLEAR]))
      else $error("Clear sequence did not zero counter");

   ovf_irq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (tick && st_q.running && !key_done
       && st_q.count == kswd_pkg::WD_CNT_MAX)
      |=> (wd_overflow_irq_o && st_q.count == kswd_pkg::WD_CNT_ZERO
           && !st_q.pointer) ##1 !wd_overflow_irq_o)
      else $error("Wrap did not raise one-cycle overflow interrupt");

   nmi_nomask_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ovf_now && mask_q == kswd_pkg::EV_NONE) |=> wd_overflow_irq_o)
      else $error("Overflow interrupt gated by mask");

   bad_first_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_wr && st_q.pointer && key_val == kswd_pkg::KEY_FIRST)
      |=> (!st_q.armed && !st_q.pointer))
      else $error("First key accepted at pointer one");

   bad_second_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_wr && !st_q.armed && key_val == kswd_pkg::KEY_SECOND && !tick)
      |=> (st_q.count == $past(st_q.count)
           && st_q.running == $past(st_q.running)))
      else $error("Unarmed second key cleared counter");

   interval_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      ovf_now |-> (ticks_since_q + kswd_pkg::WD_TICK_ONE
                   == kswd_pkg::WD_NOMINAL_TICKS_V))
      else $error("Overflow not on the 512th tick after clear");

   key_wo_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && req.cyc && req.stb && !req.we
       && req.adr == kswd_pkg::KEY_ADR) |-> (wb_dat_o == kswd_pkg::DAT_ZERO))
      else $error("Key register read back nonzero");

   other_key_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_wr && key_val != kswd_pkg::KEY_FIRST
       && key_val != kswd_pkg::KEY_SECOND)
      |=> (!st_q.armed && status_q[kswd_pkg::EV_BADKEY]))
      else $error("Other key value left sequence armed");

   bus_ack_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_new |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Ack not one cycle after request");

   armed_ptr_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_q.armed |-> st_q.pointer)
      else $error("Armed with pointer at zero");

   ovf_ptr_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (ovf_now && key_wr) |=> (!st_q.pointer && !st_q.armed))
      else $error("Key write kept pointer across overflow");

   clr_tick_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (key_done && tick)
      |=> (st_q.count == kswd_pkg::WD_CNT_ZERO && !wd_overflow_irq_o))
      else $error("Tick in clear cycle advanced counter");

   stat_set_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (events != kswd_pkg::EV_NONE) |=> ((status_q & $past(events)) == $past(events)))
      else $error("Event lost against a status clear");

   irq_sum_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (irq_o == $past(|(status_q & mask_q))))
      else $error("Summary interrupt does not follow status and mask");

   rd_idle_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == kswd_pkg::DAT_ZERO))
      else $error("Read data standing without ack");

endmodule

/* File: rtl/kswd_pkg.sv */
package kswd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Counter and time base
   localparam int             WD_CNT_W       = 9;
   localparam logic [8:0]     WD_CNT_MAX     = 9'h1FF;
   localparam logic [8:0]     WD_CNT_ZERO    = 9'h000;
   localparam logic [8:0]     WD_CNT_ONE     = 9'h001;
   localparam int             TB_TICK_HZ     = 256;
   localparam int             LS_CLK_HZ      = 32768;
   localparam int             WD_NOMINAL_S   = 2;
   // Ticks from clear to overflow at the nominal rate
   localparam int             WD_NOMINAL_TICKS = WD_NOMINAL_S * TB_TICK_HZ;
   // Low-speed clocks in one tick: worst-case early first tick
   localparam int             WD_EARLY_LS_CLKS = LS_CLK_HZ / TB_TICK_HZ;
   localparam logic [9:0]     WD_NOMINAL_TICKS_V = 10'h200;
   localparam logic [9:0]     WD_TICK_ONE    = 10'h001;
   localparam logic [9:0]     WD_TICK_ZERO   = 10'h000;

   ////////////////////////////////////////////////////////////////////////////
   // Key values
   localparam logic [3:0]     KEY_FIRST      = 4'h5;
   localparam logic [3:0]     KEY_SECOND     = 4'hA;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and register map (index, byte address is index times four)
   localparam int             WB_ADR_W       = 12;
   localparam int             WB_DAT_W       = 32;
   localparam int             WB_SEL_W       = 4;
   localparam logic [9:0]     KEY_IDX        = 10'h09F;
   localparam logic [9:0]     STAT_IDX       = 10'h0A0;
   localparam logic [9:0]     MASK_IDX       = 10'h0A1;
   localparam logic [9:0]     STATE_IDX      = 10'h0A2;
   localparam logic [1:0]     WORD_LSB       = 2'h0;
   localparam logic [11:0]    KEY_ADR        = {KEY_IDX, WORD_LSB};
   localparam logic [11:0]    STAT_ADR       = {STAT_IDX, WORD_LSB};
   localparam logic [11:0]    MASK_ADR       = {MASK_IDX, WORD_LSB};
   localparam logic [11:0]    STATE_ADR      = {STATE_IDX, WORD_LSB};
   localparam logic [31:0]    DAT_ZERO       = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Event bits, shared by status and mask
   localparam int             EV_W           = 4;
   localparam int             EV_OVF         = 0;
   localparam int             EV_START       = 1;
   localparam int             EV_CLEAR       = 2;
   localparam int             EV_BADKEY      = 3;
   localparam logic [3:0]     EV_NONE        = 4'h0;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [11:0] adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } kswd_wb_req_t;

   typedef struct packed {
      logic       running;
      logic       pointer;
      logic       armed;
      logic [8:0] count;
   } kswd_state_t;

endpackage

/* File: sim/test_key_sequence_watchdog.sv */
`timescale 1ns/1ps
module test_key_sequence_watchdog;

   ////////////////////////////////////////////////////////////////////////////
   localparam int LIMIT = 20000;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we  = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic        tap = 1'b0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        irq_o;
   logic        wd_overflow_irq_o;
   logic [31:0] exp_q[$];
   int          err_total = 0;
   int          n_checks  = 0;
   int          ovf_n     = 0;
   int          ovf0;
   int          cyc_cnt   = 0;
   int          n;
   logic [3:0]  v;

   always #5 clk = ~clk;

   kswd_watchdog kswd_watchdog_i (
      .clk_i                 (clk),
      .rst_i                 (rst),
      .wb_cyc_i              (cyc),
      .wb_stb_i              (stb),
      .wb_we_i               (we),
      .wb_adr_i              (adr),
      .wb_sel_i              (sel),
      .wb_dat_i              (dat),
      .wb_dat_o              (wb_dat_o),
      .wb_ack_o              (wb_ack_o),
      .time_base_tap_256hz_i (tap),
      .irq_o                 (irq_o),
      .wd_overflow_irq_o     (wd_overflow_irq_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Read expectations go to the queue; the monitor pairs them with acks
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      if (!w) exp_q.push_back(d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'h1;
      dat <= w ? d : 32'h0000_0000;
      // No local limit: only the bench timeout ends a wait
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [3:0] d);
      wb(1'b1, a, {28'h000_0000, d});
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      wb(1'b0, a, e);
   endtask

   // Tap phases of four cycles keep clear of the synchroniser minimum
   task automatic tick(input int t);
      repeat (t) begin
         @(posedge clk) tap <= 1'b1;
         repeat (4) @(posedge clk);
         tap <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [31:0] st(input logic r, input logic p, input logic a,
                                      input logic [8:0] c);
      return {20'h0_0000, r, p, a, c};
   endfunction

   task automatic irq_is(input logic e);
      repeat (3) @(posedge clk);
      chk({31'h0000_0000, irq_o}, {31'h0000_0000, e});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (wb_ack_o === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0)
            chk(wb_dat_o, 32'hFFFF_FFFF);
         else
            chk(wb_dat_o, exp_q.pop_front());
      end
      // Ack only while a request stands
      if (wb_ack_o === 1'b1) chk({31'h0000_0000, cyc}, 32'h0000_0001);
      if (wd_overflow_irq_o === 1'b1) ovf_n++;
   end

   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT) begin
         err_total++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(78));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(kswd_pkg::STATE_ADR, st(0, 0, 0, 9'h000));
      rd(kswd_pkg::STAT_ADR, 32'h0000_0000);
      rd(kswd_pkg::MASK_ADR, 32'h0000_0000);
      rd(kswd_pkg::KEY_ADR, 32'h0000_0000);
      rd(12'h000, 32'h0000_0000);
      tick(2);
      rd(kswd_pkg::STATE_ADR, st(0, 0, 0, 9'h000));
      $display("test reset done");

      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
      rd(kswd_pkg::STATE_ADR, st(0, 1, 1, 9'h000));
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h000));
      rd(kswd_pkg::STAT_ADR, 32'h0000_0002);
      n = 1 + ($urandom % 6);
      tick(n);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, n[8:0]));
      $display("test start done");

      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h000));
      rd(kswd_pkg::STAT_ADR, 32'h0000_0006);
      $display("test clear done");

      tick(1);
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h001));
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
      rd(kswd_pkg::STATE_ADR, st(1, 1, 0, 9'h001));
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h001));
      for (int i = 0; i < 3; i++) begin
         do v = 4'($urandom % 16); while (v == 4'h5 || v == 4'hA);
         wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
         wr(kswd_pkg::KEY_ADR, v);
         rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h001));
         wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
         wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
         rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h001));
      end
      rd(kswd_pkg::STAT_ADR, 32'h0000_000E);
      $display("test bad keys done");

      wr(kswd_pkg::STAT_ADR, 4'hF);
      rd(kswd_pkg::STAT_ADR, 32'h0000_0000);
      wr(kswd_pkg::MASK_ADR, 4'h1);
      rd(kswd_pkg::MASK_ADR, 32'h0000_0001);
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_SECOND);
      irq_is(1'b0);
      ovf0 = ovf_n;
      tick(511);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h1FF));
      chk(ovf_n, ovf0);
      // Armed key pending when the wrap hits: overflow must drop it
      wr(kswd_pkg::KEY_ADR, kswd_pkg::KEY_FIRST);
      tick(1);
      chk(ovf_n, ovf0 + 1);
      rd(kswd_pkg::STATE_ADR, st(1, 0, 0, 9'h000));
      irq_is(1'b1);
      wr(kswd_pkg::MASK_ADR, 4'h0);
      irq_is(1'b0);
      wr(kswd_pkg::MASK_ADR, 4'h1);
      irq_is(1'b1);
      wr(kswd_pkg::STAT_ADR, 4'h1);
      irq_is(1'b0);
      $display("test overflow done");

      wr(kswd_pkg::MASK_ADR, 4'h0);
      tick(512);
      chk(ovf_n, ovf0 + 2);
      irq_is(1'b0);
      rd(kswd_pkg::STAT_ADR, 32'h0000_0005);
      $display("test unmasked overflow done");
      @(posedge clk);
      conclude();
   end

endmodule
